// [design/ipnd_map.vh]
`ifndef IPND_MAP_VH
`define IPND_MAP_VH

// Register word offsets (byte addresses, one 32-bit word each)
`define IPND_OFF_CTRL      8'h00
`define IPND_OFF_RANKS     8'h04
`define IPND_OFF_LEAVE     8'h08
`define IPND_OFF_ENTER     8'h0c
`define IPND_OFF_POWER     8'h10
`define IPND_OFF_SIZE_LO   8'h14
`define IPND_OFF_SIZE_HI   8'h18
`define IPND_OFF_CAP_LO    8'h1c
`define IPND_OFF_CAP_HI    8'h20
`define IPND_OFF_USE_LO    8'h24
`define IPND_OFF_USE_HI    8'h28
`define IPND_OFF_FEAT      8'h2c
`define IPND_OFF_STATUS    8'h30
`define IPND_OFF_DESC_BASE 8'h40
`define IPND_OFF_NS_BASE   8'h60
`define IPND_OFF_NS_END    8'h7c

// Control register fields
`define IPND_CTRL_THIN     0
`define IPND_CTRL_DEALLOC  1
`define IPND_CTRL_FORMAT   2
`define IPND_CTRL_PSCNT_LO 8
`define IPND_CTRL_PSCNT_HI 13

// Ranks register fields, five bits each
`define IPND_RANK_W        5
`define IPND_RANK_WLAT_LO  0
`define IPND_RANK_WTHR_LO  8
`define IPND_RANK_RLAT_LO  16
`define IPND_RANK_RTHR_LO  24

// Descriptor field positions
`define IPND_PSD_WLAT_LO   120
`define IPND_PSD_WTHR_LO   112
`define IPND_PSD_RLAT_LO   104
`define IPND_PSD_RTHR_LO   96
`define IPND_PSD_LEAVE_LO  64
`define IPND_PSD_ENTER_LO  32
`define IPND_PSD_POWER_LO  0

// Namespace structure byte positions
`define IPND_NS_SIZE_BYTE  0
`define IPND_NS_CAP_BYTE   8
`define IPND_NS_USE_BYTE   16
`define IPND_NS_FEAT_BYTE  24
`define IPND_NS_THIN_BIT   0

// Reset values
`define IPND_RST_CTRL      32'h0000_0100
`define IPND_RST_ZERO      32'h0000_0000

`endif

// [design/ipnd_psd_pack.v]
`include "ipnd_map.vh"

// Packs one power state descriptor; purely combinational
module ipnd_psd_pack #(
	parameter RANK_W = 5
) (
	input  wire [5:0]        stateCount,
	input  wire [RANK_W-1:0] writeLatencyRank,
	input  wire [RANK_W-1:0] writeThroughputRank,
	input  wire [RANK_W-1:0] readLatencyRank,
	input  wire [RANK_W-1:0] readThroughputRank,
	input  wire [31:0]       stateLeaveTimeUs,
	input  wire [31:0]       stateEnterTimeUs,
	input  wire [15:0]       peakPowerCentiwatts,
	output reg  [255:0]      descriptor
);

	// Rank must stay below the state count; clamp to the worst legal rank
	function [RANK_W-1:0] clampRank;
		input [RANK_W-1:0] rank;
		input [5:0]        count;
		begin
			if (count == 6'h00) begin
				clampRank = {RANK_W{1'b0}};
			end else if ({1'b0, rank} >= count) begin
				clampRank = count[RANK_W-1:0] - {{(RANK_W-1){1'b0}}, 1'b1};
			end else begin
				clampRank = rank;
			end
		end
	endfunction

	// Unassigned ranges stay zero from the initial clear
	always @* begin
		descriptor = 256'h0;
		descriptor[`IPND_PSD_WLAT_LO +: RANK_W] = clampRank(writeLatencyRank, stateCount);
		descriptor[`IPND_PSD_WTHR_LO +: RANK_W] = clampRank(writeThroughputRank, stateCount);
		descriptor[`IPND_PSD_RLAT_LO +: RANK_W] = clampRank(readLatencyRank, stateCount);
		descriptor[`IPND_PSD_RTHR_LO +: RANK_W] = clampRank(readThroughputRank, stateCount);
		descriptor[`IPND_PSD_LEAVE_LO +: 32] = stateLeaveTimeUs;
		descriptor[`IPND_PSD_ENTER_LO +: 32] = stateEnterTimeUs;
		descriptor[`IPND_PSD_POWER_LO +: 16] = peakPowerCentiwatts;
	end

endmodule

// [design/ipnd_use_cnt.v]
`include "ipnd_map.vh"

// Allocated-block counter, saturating at the capacity limit
module ipnd_use_cnt #(
	parameter CNT_W = 64
) (
	input  wire             core_clk,
	input  wire             nrst,
	input  wire             clear,
	input  wire             allocPulse,
	input  wire             deallocPulse,
	input  wire             deallocEn,
	input  wire [CNT_W-1:0] limit,
	output reg  [CNT_W-1:0] count_r
);

	wire incr;  // Net allocation this cycle
	wire decr;  // Net release this cycle

	// A simultaneous allocate and release cancel each other
	assign incr = allocPulse & ~(deallocPulse & deallocEn);
	assign decr = deallocPulse & deallocEn & ~allocPulse;

	// Count stops at the capacity, falls to a lowered capacity a cycle later, never wraps below zero
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			count_r <= {CNT_W{1'b0}};
		end else if (clear) begin
			count_r <= {CNT_W{1'b0}};
		end else if (count_r > limit) begin
			count_r <= limit;
		end else if (incr && count_r < limit) begin
			count_r <= count_r + {{(CNT_W-1){1'b0}}, 1'b1};
		end else if (decr && count_r != {CNT_W{1'b0}}) begin
			count_r <= count_r - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// [design/ipnd_top.v]
// Decided for this implementation: strobed register access and the placing of the registers.
`include "ipnd_map.vh"

module ipnd_top #(
	parameter RANK_W = 5,
	parameter CNT_W  = 64
) (
	input  wire         core_clk,
	input  wire         nrst,
	input  wire [7:0]   regAddr,
	input  wire [31:0]  regWdata,
	input  wire         regWrite,
	input  wire         regRead,
	output reg  [31:0]  regRdata_r,
	input  wire         blockWritten,
	input  wire         blockDeallocated,
	output reg  [255:0] powerDescriptor_r,
	output reg  [199:0] namespaceData_r,
	output reg          namespaceUnusable_r
);

	// Address map, one 32-bit word per offset
	// 0x00 control: thin, dealloc support, formatted, state count
	// 0x04 four ranks, one byte lane each
	// 0x08 leave time, 0x0c enter time, 0x10 peak power
	// 0x14 and 0x18 size, low word then high word
	// 0x1c and 0x20 capacity, low word then high word
	// 0x24 and 0x28 allocated count, read only
	// 0x2c feature byte, 0x30 unusable status, read only
	// 0x40 to 0x5c descriptor words, lowest bits first
	// 0x60 to 0x78 namespace words; last holds byte 24
	// Halves of a 64-bit value land one at a time, no atomicity
	// Software writes both halves before trusting the pair

	// Software-written configuration
	reg              thinEnable_r;             // Thin provisioning offered
	reg              deallocSupport_r;         // Dataset deallocation offered
	reg              formatted_r;              // Namespace has been formatted
	reg  [5:0]       stateCount_r;             // Supported power state count
	reg  [RANK_W-1:0] writeLatencyRank_r;      // Relative write latency
	reg  [RANK_W-1:0] writeThroughputRank_r;   // Relative write throughput
	reg  [RANK_W-1:0] readLatencyRank_r;       // Relative read latency
	reg  [RANK_W-1:0] readThroughputRank_r;    // Relative read throughput
	reg  [31:0]      stateLeaveTimeUs_r;       // Worst leave time
	reg  [31:0]      stateEnterTimeUs_r;       // Worst enter time
	reg  [15:0]      peakPowerCentiwatts_r;    // Peak draw, centiwatts
	reg  [CNT_W-1:0] sizeSet_r;                // Size as written
	reg  [CNT_W-1:0] capSet_r;                 // Capacity as written

	// Derived values
	reg  [CNT_W-1:0] totalBlocks;              // Reported size
	reg  [CNT_W-1:0] allocatableBlocks;        // Reported capacity
	wire [CNT_W-1:0] allocatedBlocks;          // Running utilization
	wire [255:0]     descriptorNext;           // Packed descriptor
	reg  [199:0]     namespaceNext;            // Packed namespace bytes
	reg  [7:0]       featureFlags;             // Feature byte
	reg  [31:0]      readNext;                 // Read mux result

	// Control word after reset: one power state, all else off
	localparam [31:0] CTRL_RESET = `IPND_RST_CTRL;

	// True when an offset falls inside a half-open window
	function inWindow;
		input [7:0] addr;
		input [7:0] base;
		input [7:0] limit;
		begin
			inWindow = (addr >= base) && (addr < limit);
		end
	endfunction

	// Bit position of the word an offset selects in a window
	function [7:0] wordBit;
		input [7:0] addr;
		begin
			wordBit = {addr[4:2], 5'h00};
		end
	endfunction

	// Selects one 32-bit word of a 64-bit value
	function [31:0] halfWord;
		input [63:0] value;
		input        upper;
		begin
			halfWord = upper ? value[63:32] : value[31:0];
		end
	endfunction

	// Control and configuration writes
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			// Unformatted, one power state, all timings zero
			thinEnable_r          <= 1'b0;
			deallocSupport_r      <= 1'b0;
			formatted_r           <= 1'b0;
			stateCount_r          <= CTRL_RESET[`IPND_CTRL_PSCNT_HI:`IPND_CTRL_PSCNT_LO];
			writeLatencyRank_r    <= {RANK_W{1'b0}};
			writeThroughputRank_r <= {RANK_W{1'b0}};
			readLatencyRank_r     <= {RANK_W{1'b0}};
			readThroughputRank_r  <= {RANK_W{1'b0}};
			stateLeaveTimeUs_r    <= `IPND_RST_ZERO;
			stateEnterTimeUs_r    <= `IPND_RST_ZERO;
			peakPowerCentiwatts_r <= 16'h0000;
			sizeSet_r             <= {CNT_W{1'b0}};
			capSet_r              <= {CNT_W{1'b0}};
		end else if (regWrite) begin
			case (regAddr)
				// Enables, format state and state count
				`IPND_OFF_CTRL: begin
					thinEnable_r     <= regWdata[`IPND_CTRL_THIN];
					deallocSupport_r <= regWdata[`IPND_CTRL_DEALLOC];
					formatted_r      <= regWdata[`IPND_CTRL_FORMAT];
					stateCount_r     <= regWdata[`IPND_CTRL_PSCNT_HI:`IPND_CTRL_PSCNT_LO];
				end
				// Ranks stored raw; clamping happens on packing
				`IPND_OFF_RANKS: begin
					writeLatencyRank_r    <= regWdata[`IPND_RANK_WLAT_LO +: RANK_W];
					writeThroughputRank_r <= regWdata[`IPND_RANK_WTHR_LO +: RANK_W];
					readLatencyRank_r     <= regWdata[`IPND_RANK_RLAT_LO +: RANK_W];
					readThroughputRank_r  <= regWdata[`IPND_RANK_RTHR_LO +: RANK_W];
				end
				// Leave time, microseconds
				`IPND_OFF_LEAVE: begin
					stateLeaveTimeUs_r <= regWdata;
				end
				// Enter time, microseconds
				`IPND_OFF_ENTER: begin
					stateEnterTimeUs_r <= regWdata;
				end
				// Peak power; upper half dropped
				`IPND_OFF_POWER: begin
					peakPowerCentiwatts_r <= regWdata[15:0];
				end
				// Size halves; a torn pair reads odd briefly
				`IPND_OFF_SIZE_LO: begin
					sizeSet_r[31:0] <= regWdata;
				end
				// Upper size word
				`IPND_OFF_SIZE_HI: begin
					sizeSet_r[63:32] <= regWdata;
				end
				// Capacity halves, same hazard as size
				`IPND_OFF_CAP_LO: begin
					capSet_r[31:0] <= regWdata;
				end
				// Upper capacity word
				`IPND_OFF_CAP_HI: begin
					capSet_r[63:32] <= regWdata;
				end
				default: begin
					// Read-only and unmapped offsets ignore writes
				end
			endcase
		end
	end

	// Size and capacity as the host sees them
	// Before format both read zero, a defined stand-in for undefined
	always @* begin
		if (!formatted_r) begin
			// Nothing reported until formatted
			totalBlocks       = {CNT_W{1'b0}};
			allocatableBlocks = {CNT_W{1'b0}};
		end else if (!thinEnable_r) begin
			// Fully provisioned: capacity mirrors size
			totalBlocks       = sizeSet_r;
			allocatableBlocks = sizeSet_r;
		end else if (capSet_r > sizeSet_r) begin
			// Capacity written too large; held to size
			totalBlocks       = sizeSet_r;
			allocatableBlocks = sizeSet_r;
		end else begin
			// Thin: capacity as written
			totalBlocks       = sizeSet_r;
			allocatableBlocks = capSet_r;
		end
	end

	// Feature byte: only the thin flag is defined
	always @* begin
		featureFlags = 8'h00;
		featureFlags[`IPND_NS_THIN_BIT] = thinEnable_r;
	end

	// Utilization; releases count only with thin and dealloc both on
	ipnd_use_cnt #(
		.CNT_W        (CNT_W)
	) useCount (
		.core_clk     (core_clk),
		.nrst         (nrst),
		.clear        (~formatted_r),
		.allocPulse   (blockWritten),
		.deallocPulse (blockDeallocated),
		.deallocEn    (thinEnable_r & deallocSupport_r),
		.limit        (allocatableBlocks),
		.count_r      (allocatedBlocks)
	);

	// Descriptor packing with rank clamping
	ipnd_psd_pack #(
		.RANK_W              (RANK_W)
	) psdPack (
		.stateCount          (stateCount_r),
		.writeLatencyRank    (writeLatencyRank_r),
		.writeThroughputRank (writeThroughputRank_r),
		.readLatencyRank     (readLatencyRank_r),
		.readThroughputRank  (readThroughputRank_r),
		.stateLeaveTimeUs    (stateLeaveTimeUs_r),
		.stateEnterTimeUs    (stateEnterTimeUs_r),
		.peakPowerCentiwatts (peakPowerCentiwatts_r),
		.descriptor          (descriptorNext)
	);

	// Namespace bytes 0 to 24, little-endian fields
	always @* begin
		namespaceNext = 200'h0;
		namespaceNext[`IPND_NS_SIZE_BYTE*8 +: 64] = totalBlocks;
		namespaceNext[`IPND_NS_CAP_BYTE*8 +: 64]  = allocatableBlocks;
		namespaceNext[`IPND_NS_USE_BYTE*8 +: 64]  = allocatedBlocks;
		namespaceNext[`IPND_NS_FEAT_BYTE*8 +: 8]  = featureFlags;
	end

	// Structures registered so outputs come from flops
	// One cycle of lag after any change; readers tolerate it
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			powerDescriptor_r   <= 256'h0;
			namespaceData_r     <= 200'h0;
			namespaceUnusable_r <= 1'b1;
		end else begin
			powerDescriptor_r   <= descriptorNext;
			namespaceData_r     <= namespaceNext;
			namespaceUnusable_r <= (allocatableBlocks == {CNT_W{1'b0}});
		end
	end

	// Read mux; structure windows read the registered copies
	always @* begin
		readNext = 32'h0000_0000;
		if (inWindow(regAddr, `IPND_OFF_DESC_BASE, `IPND_OFF_NS_BASE)) begin
			// Eight descriptor words, lowest bits first
			readNext = powerDescriptor_r[wordBit(regAddr) +: 32];
		end else if (inWindow(regAddr, `IPND_OFF_NS_BASE, `IPND_OFF_NS_END)) begin
			// Seven namespace words; top word holds byte 24 only
			if (regAddr[4:2] == 3'h6) begin
				readNext = {24'h000000, namespaceData_r[199:192]};
			end else begin
				readNext = namespaceData_r[wordBit(regAddr) +: 32];
			end
		end else begin
			case (regAddr)
				// Enables and state count read back
				`IPND_OFF_CTRL: begin
					readNext[`IPND_CTRL_THIN]    = thinEnable_r;
					readNext[`IPND_CTRL_DEALLOC] = deallocSupport_r;
					readNext[`IPND_CTRL_FORMAT]  = formatted_r;
					readNext[`IPND_CTRL_PSCNT_HI:`IPND_CTRL_PSCNT_LO] = stateCount_r;
				end
				// Raw ranks, before clamping
				`IPND_OFF_RANKS: begin
					readNext[`IPND_RANK_WLAT_LO +: RANK_W] = writeLatencyRank_r;
					readNext[`IPND_RANK_WTHR_LO +: RANK_W] = writeThroughputRank_r;
					readNext[`IPND_RANK_RLAT_LO +: RANK_W] = readLatencyRank_r;
					readNext[`IPND_RANK_RTHR_LO +: RANK_W] = readThroughputRank_r;
				end
				// Leave time as written
				`IPND_OFF_LEAVE: begin
					readNext = stateLeaveTimeUs_r;
				end
				// Enter time as written
				`IPND_OFF_ENTER: begin
					readNext = stateEnterTimeUs_r;
				end
				// Peak power, upper half zero
				`IPND_OFF_POWER: begin
					readNext[15:0] = peakPowerCentiwatts_r;
				end
				// Size as written, not as reported
				`IPND_OFF_SIZE_LO: begin
					readNext = halfWord(sizeSet_r, 1'b0);
				end
				// Upper size word
				`IPND_OFF_SIZE_HI: begin
					readNext = halfWord(sizeSet_r, 1'b1);
				end
				// Capacity as written, before limiting
				`IPND_OFF_CAP_LO: begin
					readNext = halfWord(capSet_r, 1'b0);
				end
				// Upper capacity word
				`IPND_OFF_CAP_HI: begin
					readNext = halfWord(capSet_r, 1'b1);
				end
				// Live count, one cycle ahead of the window
				`IPND_OFF_USE_LO: begin
					readNext = halfWord(allocatedBlocks, 1'b0);
				end
				// Upper count word
				`IPND_OFF_USE_HI: begin
					readNext = halfWord(allocatedBlocks, 1'b1);
				end
				// Feature byte, reserved bits zero
				`IPND_OFF_FEAT: begin
					readNext[7:0] = featureFlags;
				end
				// Unusable flag alone
				`IPND_OFF_STATUS: begin
					readNext[0] = namespaceUnusable_r;
				end
				default: begin
					// Unmapped offsets read zero
					readNext = 32'h0000_0000;
				end
			endcase
		end
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			regRdata_r <= 32'h0000_0000;
		end else if (regRead) begin
			regRdata_r <= readNext;
		end else begin
			regRdata_r <= 32'h0000_0000;
		end
	end

endmodule

// [test/ipnd_monitor.sv]
module ipnd_monitor (
	input wire         core_clk,
	input wire         nrst,
	input wire [7:0]   regAddr,
	input wire [31:0]  regWdata,
	input wire         regWrite,
	input wire         regRead,
	input wire [31:0]  regRdata_r,
	input wire         blockWritten,
	input wire         blockDeallocated,
	input wire [255:0] powerDescriptor_r,
	input wire [199:0] namespaceData_r,
	input wire         namespaceUnusable_r
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0]  ctrl_r;                  // Shadow of control word
	wire  [5:0]   psCnt = ctrl_r[13:8];    // Supported state count
	wire  [255:0] pd = powerDescriptor_r;
	wire  [63:0]  nsSize = namespaceData_r[63:0];
	wire  [63:0]  nsCap = namespaceData_r[127:64];
	wire  [63:0]  nsUse = namespaceData_r[191:128];
	wire          thin = namespaceData_r[192];
	// Ports hide the state count and dealloc support, so shadow them
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			ctrl_r <= 32'h0000_0100;
		else if (regWrite && regAddr == 8'h00)
			ctrl_r <= regWdata;
	end
	function automatic logic rankOk(input logic [4:0] r, input logic [5:0] n);
		return ({1'b0, r} < n) || (n == 6'h00 && r == 5'h00);
	endfunction
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	// Count steady long enough for the descriptor to catch up
	sequence s_cnt_steady;
		$stable(psCnt) [*2];
	endsequence
	sequence s_cap_steady;
		$stable(nsCap) [*3];
	endsequence
	// Nothing just before, so the structure shows the live count
	sequence s_settled;
		!regWrite && !$past(regWrite) && !$past(blockWritten) && !$past(blockDeallocated);
	endsequence
	sequence s_hold;
		!regWrite && !blockWritten && !blockDeallocated;
	endsequence
	property p_wlat;
		s_cnt_steady |-> rankOk(pd[124:120], psCnt);
	endproperty
	property p_wthr;
		s_cnt_steady |-> rankOk(pd[116:112], psCnt);
	endproperty
	property p_rlat;
		s_cnt_steady |-> rankOk(pd[108:104], psCnt);
	endproperty
	property p_rthr;
		s_cnt_steady |-> rankOk(pd[100:96], psCnt);
	endproperty
	property p_unusable;
		s_cap_steady |-> namespaceUnusable_r == (nsCap == 64'h0);
	endproperty
	property p_use_cap;
		s_cap_steady |-> nsUse <= nsCap;
	endproperty
	property p_alloc;
		s_settled ##0 (blockWritten && !blockDeallocated && nsUse < nsCap) ##1 s_hold
			|=> nsUse == $past(nsUse, 2) + 64'h1;
	endproperty
	property p_dealloc;
		s_settled ##0 (blockDeallocated && !blockWritten && thin && ctrl_r[1] && nsUse != 64'h0)
			##1 s_hold |=> nsUse == $past(nsUse, 2) - 64'h1;
	endproperty
	property p_thin_off;
		!thin |-> nsCap == nsSize && namespaceData_r[199:193] == 7'h00;
	endproperty
	a_wlat: assert property (p_wlat) else $error("write latency rank too large");
	a_wthr: assert property (p_wthr) else $error("write throughput rank too large");
	a_rlat: assert property (p_rlat) else $error("read latency rank too large");
	a_rthr: assert property (p_rthr) else $error("read throughput rank too large");
	a_unusable: assert property (p_unusable) else $error("unusable flag wrong");
	a_use_cap: assert property (p_use_cap) else $error("allocated above capacity");
	a_alloc: assert property (p_alloc) else $error("write did not allocate");
	a_dealloc: assert property (p_dealloc) else $error("dealloc not reflected");
	a_thin_off: assert property (p_thin_off) else $error("capacity differs from size");
endmodule

bind ipnd_top ipnd_monitor ipnd_monitor_inst (
	.core_clk(core_clk),
	.nrst(nrst),
	.regAddr(regAddr),
	.regWdata(regWdata),
	.regWrite(regWrite),
	.regRead(regRead),
	.regRdata_r(regRdata_r),
	.blockWritten(blockWritten),
	.blockDeallocated(blockDeallocated),
	.powerDescriptor_r(powerDescriptor_r),
	.namespaceData_r(namespaceData_r),
	.namespaceUnusable_r(namespaceUnusable_r)
);

// [test/ipnd_cmd_model.sv]
// Command side: issues bursts of block allocations or releases
module ipnd_cmd_model (
	input  wire       core_clk,
	input  wire       nrst,
	input  wire       start,
	input  wire       dealloc,
	input  wire [7:0] count,
	input  wire       slow,
	output logic      blockWritten,
	output logic      blockDeallocated,
	output wire       busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] left_r;    // Events still to issue
	logic       kind_r;    // Burst releases blocks
	logic       slow_r;    // Gap after each event
	logic       gap_r;     // Gap cycle pending
	assign busy = left_r != 8'h00;
	// One event a cycle, or every other cycle when slow
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			left_r <= 8'h00;
			kind_r <= 1'b0;
			slow_r <= 1'b0;
			gap_r <= 1'b0;
			blockWritten <= 1'b0;
			blockDeallocated <= 1'b0;
		end else begin
			blockWritten <= 1'b0;
			blockDeallocated <= 1'b0;
			gap_r <= 1'b0;
			if (start) begin
				left_r <= count;
				kind_r <= dealloc;
				slow_r <= slow;
			end else if (busy && !gap_r) begin
				blockWritten <= !kind_r;
				blockDeallocated <= kind_r;
				left_r <= left_r - 8'h01;
				gap_r <= slow_r;
			end
		end
	end
endmodule

// [test/ipnd_top_tb.sv]
module ipnd_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic         core_clk, nrst, regWrite, regRead;
	logic [7:0]   regAddr;
	logic [31:0]  regWdata;
	logic         evStart, evDealloc, evSlow;  // Event burst control
	logic [7:0]   evCount;                     // Burst length
	wire          evBusy, blockWritten, blockDeallocated, namespaceUnusable_r;
	wire  [31:0]  regRdata_r;
	wire  [255:0] powerDescriptor_r;
	wire  [199:0] namespaceData_r;
	logic [31:0]  rs, ctrl;                    // Random state, expected control
	logic [63:0]  nsz, capW, used;             // Expected namespace state
	int           error_cnt, compares;
	int           cyc = 0;                     // Watchdog
	ipnd_top ipnd_top_inst (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata_r(regRdata_r), .blockWritten(blockWritten),
		.blockDeallocated(blockDeallocated), .powerDescriptor_r(powerDescriptor_r),
		.namespaceData_r(namespaceData_r), .namespaceUnusable_r(namespaceUnusable_r));
	ipnd_cmd_model ipnd_cmd_model_inst (.core_clk(core_clk), .nrst(nrst),
		.start(evStart), .dealloc(evDealloc), .count(evCount), .slow(evSlow),
		.blockWritten(blockWritten), .blockDeallocated(blockDeallocated), .busy(evBusy));
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// Out-of-range ranks clamp to one below the count
	function automatic logic [4:0] rk(input logic [4:0] r, input logic [5:0] n);
		return (n == 6'h00) ? 5'h00 : ({1'b0, r} < n) ? r : 5'(n - 6'h01);
	endfunction
	function automatic logic [63:0] capRep();
		return !ctrl[2] ? 64'h0 : (!ctrl[0] || capW > nsz) ? nsz : capW;
	endfunction
	task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Strobe drops for a cycle so back-to-back calls never clash
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 cmp(regRdata_r, e);
		@(posedge core_clk);
	endtask
	task automatic checkNs();
		logic [63:0] c;
		c = capRep();
		repeat (2) @(posedge core_clk);
		#1 cmp(namespaceData_r[191:0], {used, c, ctrl[2] ? nsz : 64'h0});
		if (ctrl[2])
			cmp(namespaceData_r[199:192], {7'h00, ctrl[0]});
		cmp(namespaceUnusable_r, c == 64'h0);
	endtask
	// Unformat first so the count restarts from zero
	task automatic setNs(input logic [31:0] c);
		wr(8'h00, 32'h0000_0100);
		wr(8'h14, nsz[31:0]);
		wr(8'h18, nsz[63:32]);
		wr(8'h1c, capW[31:0]);
		wr(8'h20, capW[63:32]);
		wr(8'h00, c);
		ctrl = c;
		used = 64'h0;
		checkNs();
	endtask
	task automatic events(input logic dl, input logic [7:0] n, input logic slow);
		evDealloc <= dl;
		evCount <= n;
		evSlow <= slow;
		evStart <= 1'b1;
		@(posedge core_clk);
		evStart <= 1'b0;
		#1;
		while (evBusy)
			#40;
		for (int i = 0; i < n; i++)
			if (!dl && used < capRep())
				used++;
			else if (dl && ctrl[1:0] == 2'b11 && used != 64'h0)
				used--;
		@(posedge core_clk);
		checkNs();
	endtask
	task automatic close_out();
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Run takes about 700 cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		logic [31:0]  r;
		logic [255:0] e;
		logic [5:0]   n;
		{rs, ctrl, error_cnt, compares} = {32'h0000_001e, 32'h0000_0100, 64'h0};
		{nrst, regAddr, regWdata, regWrite, regRead} = 43'h0;
		{evStart, evDealloc, evSlow, evCount, nsz, capW, used} = 203'h0;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		checkNs();
		// Count zero and one first, then random counts and ranks
		for (int k = 0; k < 8; k++) begin
			n = (k == 0) ? 6'h00 : (k == 1) ? 6'h01 : 6'(xs());
			r = (k < 2) ? 32'h1f1f_1f1f : xs();
			e = {131'h0, rk(r[4:0], n), 3'h0, rk(r[12:8], n), 3'h0, rk(r[20:16], n), 3'h0,
				rk(r[28:24], n), xs(), xs(), 16'h0, 16'(xs())};
			wr(8'h00, {18'h0, n, 8'h04});
			wr(8'h04, r);
			wr(8'h08, e[95:64]);
			wr(8'h0c, e[63:32]);
			wr(8'h10, {16'hffff, e[15:0]});
			#1 cmp(powerDescriptor_r, e);
			for (int j = 0; j < 8; j++)
				rd(8'h40 + 8'(4 * j), e[32 * j +: 32]);
		end
		nsz = {xs(), xs()};
		capW = 64'h5;
		setNs(32'h0000_0104);
		events(1'b0, 8'h07, 1'b0);
		events(1'b1, 8'h03, 1'b0);
		rd(8'h2c, 32'h0);
		setNs(32'h0000_0107);
		events(1'b0, 8'h07, 1'b1);
		events(1'b1, 8'h03, 1'b1);
		wr(8'h24, 32'hffff_ffff);
		rd(8'h24, used[31:0]);
		rd(8'h3c, 32'h0);
		rd(8'h2c, 32'h1);
		rd(8'h60, nsz[31:0]);
		rd(8'h70, used[31:0]);
		rd(8'h78, 32'h1);
		events(1'b1, 8'h04, 1'b0);
		capW = 64'h0;
		setNs(32'h0000_0105);
		events(1'b0, 8'h03, 1'b0);
		rd(8'h30, 32'h1);
		for (int k = 0; k < 10; k++) begin
			nsz = 64'(xs() % 9);
			capW = 64'(xs() % 9);
			setNs({24'h0000_01, 5'h0, 3'(xs())});
			events(1'b0, 8'(xs() % 12), 1'(xs()));
			events(1'b1, 8'(xs() % 6), 1'(xs()));
		end
		close_out();
	end
endmodule
